// file: design/pdcg_cfg.svh
`ifndef PDCG_CFG_SVH
`define PDCG_CFG_SVH

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define PDCG_ADDR_W        4
`define PDCG_OFS_CSR       4'h0
`define PDCG_OFS_CLKCFG    4'h4
`define PDCG_OFS_STATUS    4'h8

// ---------------------------------------------------------------
// Power-down field
// ---------------------------------------------------------------
`define PDCG_FLD_HI        15
`define PDCG_FLD_LO        10
`define PDCG_FLD_W         6
`define PDCG_CODE_NONE     6'h00
`define PDCG_CODE_LS_EN    6'h09
`define PDCG_CODE_LS_ANY   6'h11
`define PDCG_CODE_PLLOUT   6'h1A
`define PDCG_CODE_PLLIN    6'h1C
`define PDCG_FLD_RST       6'h00

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define PDCG_ENTRY_DLY     4'h8
`define PDCG_CNT_W         4
`define PDCG_LOCK_US       75
`define PDCG_CLK_MHZ       10

`endif

// file: design/pdcg_pkg.sv
package pdcg_pkg;

	typedef enum logic [4:0] {
		PDCG_RUN    = 5'h01,
		PDCG_ARMED  = 5'h02,
		PDCG_LIGHT  = 5'h04,
		PDCG_DEEP   = 5'h08,
		PDCG_RELOCK = 5'h10
	} pdcg_state_t;

endpackage

// file: design/pdcg_power_down.sv
`timescale 1ns/1ns
`include "pdcg_cfg.svh"

// Behaviour
// - Light sleep takes effect eight to nine cycles after the field write.
// - Wake by non-enabled interrupt resumes at sleep point, no service routine.
// - Wake by enabled interrupt runs service routine, then resumes.
// - Service routine only when global and non-maskable enables are both set.
// - Deep modes end only on device reset, never on interrupts.
// - Field at bits 15..10; zero means none; other codes reserved.
// - Code 001001 selects light sleep woken by enabled interrupt only.
// - Code 010001 selects light sleep woken by any interrupt.
// - Light sleep gates CPU clock; interrupt logic keeps running.
// - DMA between peripherals and internal memory continues during light sleep.
// - Code 011010 stops PLL output; state kept, outputs frozen.
// - Code 011100 stops PLL input; state kept, outputs frozen.
// - After reset from input-stop mode, wait for PLL re-lock before running.
// - Asynchronous or externally clocked peripherals may still toggle in deep modes.
// - SDRAM clock output matches secondary clock, period two CPU clocks.
// - Burst-SRAM clock runs full or half rate per its configuration.
// - CPU clock comes from reference input, multiplied or bypassed.
module pdcg_power_down
	import pdcg_pkg::*;
#(
	parameter int LOCK_CYCLES = `PDCG_LOCK_US * `PDCG_CLK_MHZ,
	parameter int NUM_IRQ     = 4
) (
	input  wire logic                    i_core_clk,
	input  wire logic                    i_nrst,
	input  wire logic [`PDCG_ADDR_W-1:0] i_addr,
	input  wire logic [31:0]             i_wdata,
	input  wire logic                    i_wr,
	input  wire logic                    i_rd,
	input  wire logic [NUM_IRQ-1:0]      i_irq,
	input  wire logic [NUM_IRQ-1:0]      i_interrupt_enable_register,
	input  wire logic                    i_nonmaskable_enable_bit,
	input  wire logic                    i_pll_bypass,
	input  wire logic                    i_dma_req,
	output logic      [31:0]             o_rdata,
	output logic                         o_cpu_clk_en,
	output logic                         o_cpu_halt,
	output logic                         o_irq_logic_run,
	output logic                         o_dma_clk_en,
	output logic                         o_pll_out_stop,
	output logic                         o_pll_in_stop,
	output logic                         o_io_freeze,
	output logic                         o_wake_isr,
	output logic                         o_wake_resume,
	output logic                         o_cpu_clock_output,
	output logic                         o_secondary_clock_output,
	output logic                         o_sdram_clock_output,
	output logic                         o_burst_sram_clock_output
);

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [`PDCG_FLD_W-1:0] sleep_mode_field_r;
	logic                   global_interrupt_enable_r;
	logic                   burst_sram_clock_output_half_r;
	logic                   byp_s1_r;
	logic                   byp_s2_r;
	logic [`PDCG_FLD_W-1:0] armed_code_r;
	logic [`PDCG_CNT_W-1:0] entry_cnt_r;
	logic [31:0]            lock_cnt_r;
	logic                   div_r;
	pdcg_state_t            state_r;
	pdcg_state_t            state_nxt;
	logic [NUM_IRQ-1:0]     irq_s1_r;
	logic [NUM_IRQ-1:0]     irq_s2_r;
	logic [NUM_IRQ-1:0]     ien_s1_r;
	logic [NUM_IRQ-1:0]     ien_s2_r;
	logic                   nonmaskable_enable_bit_s1_r;
	logic                   nonmaskable_enable_bit_s2_r;
	logic                   dma_s1_r;
	logic                   dma_s2_r;

	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	wire logic sel_csr    = (i_addr == `PDCG_OFS_CSR);
	wire logic sel_clkcfg = (i_addr == `PDCG_OFS_CLKCFG);
	wire logic sel_status = (i_addr == `PDCG_OFS_STATUS);
	wire logic wr_csr     = i_wr && sel_csr;
	wire logic wr_clkcfg  = i_wr && sel_clkcfg;
	wire logic [`PDCG_FLD_W-1:0] wr_code = i_wdata[`PDCG_FLD_HI:`PDCG_FLD_LO];

	wire logic code_light = (wr_code == `PDCG_CODE_LS_EN) ||
		(wr_code == `PDCG_CODE_LS_ANY);
	wire logic code_deep  = (wr_code == `PDCG_CODE_PLLOUT) ||
		(wr_code == `PDCG_CODE_PLLIN);
	wire logic code_valid = code_light || code_deep;

	wire logic [NUM_IRQ-1:0] irq_en = irq_s2_r & ien_s2_r;
	wire logic any_irq     = |irq_s2_r;
	wire logic enabled_irq = |irq_en;
	wire logic wake_any    = (armed_code_r == `PDCG_CODE_LS_ANY);
	wire logic wake_ev     = wake_any ? any_irq : enabled_irq;
	wire logic isr_ok      = enabled_irq && global_interrupt_enable_r
		&& nonmaskable_enable_bit_s2_r;
	wire logic entry_done  = (entry_cnt_r == `PDCG_ENTRY_DLY - 4'h1);
	// A bypassed PLL has nothing to lock, so the wait is skipped
	wire logic lock_done   = (lock_cnt_r == 32'h0) || byp_s2_r;

	wire logic [31:0] csr_rd = {16'h0, sleep_mode_field_r, 9'h0,
		global_interrupt_enable_r};
	wire logic [31:0] status_rd = {24'h0, 3'h0, state_r};
	wire logic [31:0] rd_mux = sel_csr ? csr_rd :
		sel_clkcfg ? {31'h0, burst_sram_clock_output_half_r} :
		sel_status ? status_rd : 32'h0;

	// ---------------------------------------------------------------
	// Mode sequencer
	// ---------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			PDCG_RUN: begin
				if (wr_csr && code_valid) begin
					state_nxt = PDCG_ARMED;
				end
			end
			PDCG_ARMED: begin
				if (entry_done) begin
					state_nxt = (armed_code_r == `PDCG_CODE_LS_EN ||
						armed_code_r == `PDCG_CODE_LS_ANY) ? PDCG_LIGHT : PDCG_DEEP;
				end
			end
			PDCG_LIGHT: begin
				if (wake_ev) begin
					state_nxt = PDCG_RUN;
				end
			end
			PDCG_DEEP: begin
				state_nxt = PDCG_DEEP;
			end
			PDCG_RELOCK: begin
				if (lock_done) begin
					state_nxt = PDCG_RUN;
				end
			end
			default: begin
				state_nxt = PDCG_RUN;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// Input synchronisers
	// ---------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			irq_s1_r  <= '0;
			irq_s2_r  <= '0;
			ien_s1_r  <= '0;
			ien_s2_r  <= '0;
			nonmaskable_enable_bit_s1_r <= 1'b0;
			nonmaskable_enable_bit_s2_r <= 1'b0;
			dma_s1_r  <= 1'b0;
			dma_s2_r  <= 1'b0;
			byp_s1_r  <= 1'b0;
			byp_s2_r  <= 1'b0;
		end else begin
			irq_s1_r  <= i_irq;
			irq_s2_r  <= irq_s1_r;
			ien_s1_r  <= i_interrupt_enable_register;
			ien_s2_r  <= ien_s1_r;
			nonmaskable_enable_bit_s1_r <= i_nonmaskable_enable_bit;
			nonmaskable_enable_bit_s2_r <= nonmaskable_enable_bit_s1_r;
			dma_s1_r  <= i_dma_req;
			dma_s2_r  <= dma_s1_r;
			byp_s1_r  <= i_pll_bypass;
			byp_s2_r  <= byp_s1_r;
		end
	end

	// ---------------------------------------------------------------
	// Control registers
	// ---------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			sleep_mode_field_r        <= `PDCG_FLD_RST;
			global_interrupt_enable_r <= 1'b0;
			burst_sram_clock_output_half_r              <= 1'b0;
		end else begin
			if (wr_csr) begin
				sleep_mode_field_r        <= wr_code;
				global_interrupt_enable_r <= i_wdata[0];
			end else if (state_r == PDCG_LIGHT && wake_ev) begin
				sleep_mode_field_r <= `PDCG_CODE_NONE;
			end
			if (wr_clkcfg) begin
				burst_sram_clock_output_half_r <= i_wdata[0];
			end
		end
	end

	// Every reset waits for PLL lock unless the PLL is bypassed, as at power-up
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_r      <= PDCG_RELOCK;
			armed_code_r <= `PDCG_CODE_NONE;
			entry_cnt_r  <= '0;
			lock_cnt_r   <= 32'(LOCK_CYCLES);
		end else begin
			state_r <= state_nxt;
			if (state_r == PDCG_RUN && wr_csr) begin
				armed_code_r <= wr_code;
			end
			entry_cnt_r <= (state_r == PDCG_ARMED) ? entry_cnt_r + 4'h1 : 4'h0;
			if (state_r == PDCG_RELOCK && !lock_done) begin
				lock_cnt_r <= lock_cnt_r - 32'h1;
			end else if (state_r != PDCG_RELOCK) begin
				lock_cnt_r <= 32'h0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_rdata         <= 32'h0;
			o_cpu_clk_en    <= 1'b0;
			o_cpu_halt      <= 1'b1;
			o_irq_logic_run <= 1'b1;
			o_dma_clk_en    <= 1'b0;
			o_pll_out_stop  <= 1'b0;
			o_pll_in_stop   <= 1'b0;
			o_io_freeze     <= 1'b0;
			o_wake_isr      <= 1'b0;
			o_wake_resume   <= 1'b0;
		end else begin
			o_rdata         <= i_rd ? rd_mux : 32'h0;
			o_cpu_clk_en    <= (state_nxt == PDCG_RUN) ||
				(state_nxt == PDCG_ARMED);
			o_cpu_halt      <= (state_nxt == PDCG_LIGHT) ||
				(state_nxt == PDCG_DEEP) || (state_nxt == PDCG_RELOCK);
			o_irq_logic_run <= (state_nxt != PDCG_DEEP);
			o_dma_clk_en    <= (state_nxt != PDCG_DEEP) &&
				(state_nxt != PDCG_RELOCK) && (dma_s2_r || 1'b1);
			o_pll_out_stop  <= (state_nxt == PDCG_DEEP) &&
				(armed_code_r == `PDCG_CODE_PLLOUT);
			o_pll_in_stop   <= (state_nxt == PDCG_DEEP) &&
				(armed_code_r == `PDCG_CODE_PLLIN);
			o_io_freeze     <= (state_nxt == PDCG_DEEP);
			o_wake_isr      <= (state_r == PDCG_LIGHT) && wake_ev && isr_ok;
			o_wake_resume   <= (state_r == PDCG_LIGHT) && wake_ev && !isr_ok;
		end
	end

	// ---------------------------------------------------------------
	// Output clocks
	// ---------------------------------------------------------------
	wire logic clk_run = (state_r != PDCG_DEEP);
	// Secondary clock toggles every second edge: period of two CPU clocks
	wire logic sec_nxt = div_r ? ~o_secondary_clock_output : o_secondary_clock_output;

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			div_r                     <= 1'b0;
			o_cpu_clock_output        <= 1'b0;
			o_secondary_clock_output  <= 1'b0;
			o_sdram_clock_output      <= 1'b0;
			o_burst_sram_clock_output <= 1'b0;
		end else if (clk_run) begin
			div_r                     <= ~div_r;
			o_cpu_clock_output        <= ~o_cpu_clock_output;
			o_secondary_clock_output  <= sec_nxt;
			o_sdram_clock_output      <= sec_nxt;
			o_burst_sram_clock_output <= burst_sram_clock_output_half_r ? sec_nxt :
				~o_burst_sram_clock_output;
		end
	end

endmodule

// file: sim/pdcg_properties.sv
`timescale 1ns/1ns
`include "pdcg_cfg.svh"
module pdcg_properties #(
	parameter int NUM_IRQ = 4
) (
	input wire logic                    i_core_clk,
	input wire logic                    i_nrst,
	input wire logic [`PDCG_ADDR_W-1:0] i_addr,
	input wire logic [31:0]             i_wdata,
	input wire logic                    i_wr,
	input wire logic                    i_nonmaskable_enable_bit,
	input wire logic                    o_cpu_clk_en,
	input wire logic                    o_cpu_halt,
	input wire logic                    o_irq_logic_run,
	input wire logic                    o_dma_clk_en,
	input wire logic                    o_pll_out_stop,
	input wire logic                    o_pll_in_stop,
	input wire logic                    o_io_freeze,
	input wire logic                    o_wake_isr,
	input wire logic                    o_wake_resume,
	input wire logic                    o_cpu_clock_output,
	input wire logic                    o_secondary_clock_output,
	input wire logic                    o_sdram_clock_output,
	input wire logic                    o_burst_sram_clock_output
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);
	wire       deep_w = o_pll_out_stop | o_pll_in_stop;
	logic      ran_r;
	// Halt before the first run after reset is the relock wait
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ran_r <= 1'b0;
		end else if (o_cpu_clk_en) begin
			ran_r <= 1'b1;
		end
	end
	wire [5:0] fld_w  = i_wdata[15:10];
	wire       ls_w   = fld_w == `PDCG_CODE_LS_EN || fld_w == `PDCG_CODE_LS_ANY;
	wire       go_w   = i_wr && i_addr == `PDCG_OFS_CSR && ls_w && !o_cpu_halt;
	wire [3:0] clks_w = {o_cpu_clock_output, o_secondary_clock_output,
		o_sdram_clock_output, o_burst_sram_clock_output};
	sequence s_entry;
		##1 (!o_cpu_halt) [*7] ##[1:2] o_cpu_halt;
	endsequence
	sequence s_sec_cycle;
		o_secondary_clock_output [*2] ##1 (!o_secondary_clock_output) [*2]
			##1 o_secondary_clock_output;
	endsequence
	entry_delay_a: assert property (go_w |-> s_entry)
		else $error("light sleep entry delay wrong");
	deep_hold_a: assert property (deep_w |=> $stable({o_pll_out_stop, o_pll_in_stop}))
		else $error("deep mode left without reset");
	deep_freeze_a: assert property (deep_w |-> o_io_freeze && o_cpu_halt && !o_dma_clk_en)
		else $error("deep mode not frozen");
	clk_frozen_a: assert property (deep_w ##1 deep_w |-> $stable(clks_w))
		else $error("output clocks move in deep mode");
	light_gate_a: assert property (o_cpu_halt |-> !o_cpu_clk_en && (o_irq_logic_run || deep_w))
		else $error("halt without clock gate");
	dma_run_a: assert property ((o_cpu_halt && !o_io_freeze && ran_r) [*3] |-> o_dma_clk_en)
		else $error("dma clock stopped in light sleep");
	wake_pulse_a: assert property ((o_wake_isr || o_wake_resume) |-> $past(o_cpu_halt)
		##1 !o_wake_isr && !o_wake_resume && !o_cpu_halt)
		else $error("wake pulse malformed");
	isr_gate_a: assert property (o_wake_isr |-> $past(i_nonmaskable_enable_bit, 3))
		else $error("service wake without nonmaskable enable");
	sdram_match_a: assert property (o_sdram_clock_output == o_secondary_clock_output)
		else $error("sdram clock differs from secondary");
	sec_period_a: assert property ($rose(o_secondary_clock_output) && !o_io_freeze
		|-> s_sec_cycle or (##[1:4] o_io_freeze))
		else $error("secondary clock period wrong");
endmodule
bind pdcg_power_down pdcg_properties #(.NUM_IRQ(NUM_IRQ)) chk_u (.i_core_clk, .i_nrst,
	.i_addr, .i_wdata, .i_wr, .i_nonmaskable_enable_bit, .o_cpu_clk_en, .o_cpu_halt,
	.o_irq_logic_run, .o_dma_clk_en, .o_pll_out_stop, .o_pll_in_stop, .o_io_freeze,
	.o_wake_isr, .o_wake_resume, .o_cpu_clock_output, .o_secondary_clock_output,
	.o_sdram_clock_output, .o_burst_sram_clock_output);

// file: sim/pdcg_irq_model.sv
`timescale 1ns/1ns
module pdcg_irq_model #(
	parameter int NUM_IRQ = 4
) (
	input  wire logic               i_clk,
	input  wire logic               i_nrst,
	input  wire logic               i_fire,
	input  wire logic [1:0]         i_line,
	input  wire logic               i_wake,
	output logic      [NUM_IRQ-1:0] o_irq
);
	// Source holds its line until the wake is seen
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_irq <= '0;
		end else if (i_wake) begin
			o_irq <= '0;
		end else if (i_fire) begin
			o_irq[i_line] <= 1'b1;
		end
	end
endmodule

// file: sim/power_down_clock_gating_tb.sv
`timescale 1ns/1ns
`include "pdcg_cfg.svh"
module power_down_clock_gating_tb;
	logic        i_core_clk = 1'b0;
	logic        i_nrst = 1'b0;
	logic [3:0]  i_addr = '0;
	logic [31:0] i_wdata = '0;
	logic        i_wr = 1'b0;
	logic        i_rd = 1'b0;
	logic [3:0]  i_irq;
	logic [3:0]  i_interrupt_enable_register = '0;
	logic        i_nonmaskable_enable_bit = 1'b0;
	logic        i_pll_bypass = 1'b0;
	logic        i_dma_req = 1'b0;
	logic        fire = 1'b0;
	logic [1:0]  line = '0;
	logic [31:0] o_rdata, v, seed = 32'hE32B4C43;
	logic        o_cpu_clk_en, o_cpu_halt, o_irq_logic_run, o_dma_clk_en, o_pll_out_stop;
	logic        o_pll_in_stop, o_io_freeze, o_wake_isr, o_wake_resume, o_cpu_clock_output;
	logic        o_secondary_clock_output, o_sdram_clock_output, o_burst_sram_clock_output;
	logic [3:0]  rb, rs;
	int          fail_count = 0, checks_done = 0, cyc = 0;
	always #50 i_core_clk = ~i_core_clk;
	pdcg_power_down #(.LOCK_CYCLES(8)) dut_u (.i_core_clk, .i_nrst, .i_addr, .i_wdata,
		.i_wr, .i_rd, .i_irq, .i_interrupt_enable_register, .i_nonmaskable_enable_bit,
		.i_pll_bypass, .i_dma_req, .o_rdata, .o_cpu_clk_en, .o_cpu_halt, .o_irq_logic_run,
		.o_dma_clk_en, .o_pll_out_stop, .o_pll_in_stop, .o_io_freeze, .o_wake_isr,
		.o_wake_resume, .o_cpu_clock_output, .o_secondary_clock_output,
		.o_sdram_clock_output, .o_burst_sram_clock_output);
	pdcg_irq_model irq_u (.i_clk(i_core_clk), .i_nrst(i_nrst), .i_fire(fire),
		.i_line(line), .i_wake(o_wake_isr | o_wake_resume), .o_irq(i_irq));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	function automatic logic [31:0] control_status_register(input logic [5:0] c, input logic g);
		return {16'h0000, c, 9'h000, g};
	endfunction
	task finish_test;
		if (fail_count == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	always @(posedge i_core_clk) begin
		seed <= xs(seed);
		i_dma_req <= seed[0];
		i_pll_bypass <= seed[1];
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fail_count++;
			finish_test();
		end
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge i_core_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask
	task rst;
		@(posedge i_core_clk);
		i_nrst <= 1'b0;
		repeat (5) @(posedge i_core_clk);
		i_nrst <= 1'b1;
		tick(12);
	endtask
	task irq_on(input logic [1:0] l);
		@(posedge i_core_clk);
		fire <= 1'b1;
		line <= l;
		@(posedge i_core_clk);
		fire <= 1'b0;
	endtask
	task light(input logic [5:0] c, input logic g, input logic nm, input logic [3:0] ie,
		input logic [1:0] l, input logic [1:0] e);
		logic [1:0] w;
		int         n;
		i_nonmaskable_enable_bit <= nm;
		i_interrupt_enable_register <= ie;
		wr(`PDCG_OFS_CSR, control_status_register(c, g));
		n = 0;
		while (!o_cpu_halt && n < 20) begin
			@(posedge i_core_clk) #1 n++;
		end
		chk("entry_delay_ok", 32'h1, {31'h0, n == 8 || n == 9});
		chk("light_clk_irq_dma", 32'h3, {o_cpu_clk_en, o_irq_logic_run, o_dma_clk_en});
		irq_on(l);
		w = 2'b00;
		repeat (12) begin
			@(posedge i_core_clk) #1;
			if (o_wake_isr) w = 2'b10;
			if (o_wake_resume) w = 2'b01;
		end
		chk("wake_kind", e, w);
		if (e != 2'b00) begin
			rd(`PDCG_OFS_CSR, v);
			chk("field_after_wake", 32'h0, v[15:10]);
		end else begin
			rst();
		end
	endtask
	initial begin
		rst();
		rd(`PDCG_OFS_CSR, v);
		chk("csr_reset", 32'h0, v);
		rd(`PDCG_OFS_STATUS, v);
		chk("status_run", 32'h1, v[4:0]);
		rd(4'hC, v);
		chk("unmapped_read", 32'h0, v);
		wr(`PDCG_OFS_CSR, control_status_register(6'h05, 1'b0));
		tick(12);
		rd(`PDCG_OFS_CSR, v);
		chk("reserved_readback", 32'h05, v[15:10]);
		chk("reserved_no_halt", 32'h0, o_cpu_halt);
		wr(`PDCG_OFS_CSR, control_status_register(`PDCG_CODE_NONE, 1'b0));
		for (int k = 0; k < 2; k++) begin
			wr(`PDCG_OFS_CLKCFG, k);
			tick(1);
			{rb, rs} = '0;
			repeat (8) begin
				v[1:0] = {o_burst_sram_clock_output, o_sdram_clock_output};
				tick(1);
				rb += {3'b000, o_burst_sram_clock_output & !v[1]};
				rs += {3'b000, o_sdram_clock_output & !v[0]};
			end
			chk("sdram_rises", 32'h2, rs);
			chk("burst_rises", k ? 32'h2 : 32'h4, rb);
		end
		light(`PDCG_CODE_LS_EN, 1'b1, 1'b1, 4'hF, seed[3:2], 2'b10);
		light(`PDCG_CODE_LS_EN, 1'b0, 1'b1, 4'hF, seed[5:4], 2'b01);
		light(`PDCG_CODE_LS_EN, 1'b1, 1'b0, 4'hF, seed[7:6], 2'b01);
		light(`PDCG_CODE_LS_EN, 1'b1, 1'b1, 4'hE, 2'b00, 2'b00);
		light(`PDCG_CODE_LS_ANY, 1'b1, 1'b1, 4'hE, 2'b00, 2'b01);
		light(`PDCG_CODE_LS_ANY, 1'b1, 1'b1, 4'hF, seed[3:2], 2'b10);
		for (int k = 0; k < 2; k++) begin
			wr(`PDCG_OFS_CSR, control_status_register(k ? `PDCG_CODE_PLLIN : `PDCG_CODE_PLLOUT, 1'b1));
			tick(12);
			chk("deep_stop", k ? 32'h1 : 32'h2, {o_pll_out_stop, o_pll_in_stop});
			chk("deep_freeze", 32'h1, o_io_freeze);
			v = {o_cpu_clock_output, o_secondary_clock_output, o_burst_sram_clock_output};
			irq_on(seed[3:2]);
			tick(20);
			chk("deep_kept", k ? 32'h1 : 32'h2, {o_pll_out_stop, o_pll_in_stop});
			chk("clocks_frozen", v, {o_cpu_clock_output, o_secondary_clock_output,
				o_burst_sram_clock_output});
			rst();
			chk("reset_runs", 32'h1, {o_pll_out_stop, o_pll_in_stop, o_cpu_clk_en});
			rd(`PDCG_OFS_CSR, v);
			chk("field_reset", 32'h0, v);
		end
		finish_test();
	end
endmodule
